//--- tme_defs.vh
`ifndef TME_DEFS_VH
`define TME_DEFS_VH

// ----------------------------------------
// Message type codes
// ----------------------------------------
`define TME_TC_DEBUG_STATE 6'h00
`define TME_TC_OWNER_TRACE 6'h02
`define TME_TC_DIRECT_JUMP 6'h03
`define TME_TC_INDIRECT_JUMP 6'h04
`define TME_TC_WRITE_TRACE 6'h05
`define TME_TC_READ_TRACE 6'h06
`define TME_TC_ERROR 6'h08
`define TME_TC_PROGRAM_RESYNC 6'h09
`define TME_TC_DIRECT_JUMP_RESYNC 6'h0b
`define TME_TC_INDIRECT_JUMP_RESYNC 6'h0c
`define TME_TC_WRITE_TRACE_RESYNC 6'h0d
`define TME_TC_READ_TRACE_RESYNC 6'h0e
`define TME_TC_WATCH_HIT 6'h0f
`define TME_TC_RESOURCE_OVERFLOW 6'h1b
`define TME_TC_CORRELATION 6'h21
`define TME_TC_TRACE_WATCH_HIT 6'h38
`define TME_TC_DIRECT_JUMP_TARGET 6'h39
`define TME_TC_ATOMIC_UPDATE 6'h3a
`define TME_TC_ATOMIC_UPDATE_RESYNC 6'h3b
`define TME_TC_VENDOR_EXT 6'h3f

// ----------------------------------------
// Message kind selectors on the request port
// ----------------------------------------
`define TME_KIND_DEBUG_STATE 5'h00
`define TME_KIND_OWNER_TRACE 5'h01
`define TME_KIND_ERROR 5'h02
`define TME_KIND_DIRECT_JUMP 5'h03
`define TME_KIND_DIRECT_JUMP_TARGET 5'h04
`define TME_KIND_INDIRECT_JUMP 5'h05
`define TME_KIND_PROGRAM_RESYNC 5'h06
`define TME_KIND_DIRECT_JUMP_RESYNC 5'h07
`define TME_KIND_INDIRECT_JUMP_RESYNC 5'h08
`define TME_KIND_RESOURCE_OVERFLOW 5'h09
`define TME_KIND_CORRELATION 5'h0a
`define TME_KIND_WRITE_TRACE 5'h0b
`define TME_KIND_READ_TRACE 5'h0c
`define TME_KIND_ATOMIC_UPDATE 5'h0d
`define TME_KIND_WRITE_TRACE_RESYNC 5'h0e
`define TME_KIND_READ_TRACE_RESYNC 5'h0f
`define TME_KIND_ATOMIC_UPDATE_RESYNC 5'h10
`define TME_KIND_WATCH_HIT 5'h11
`define TME_KIND_TRACE_WATCH_HIT 5'h12

// ----------------------------------------
// Packet field widths in bits
// ----------------------------------------
`define TME_W_TYPE 6'h06
`define TME_W_WORD 6'h20
`define TME_W_COUNT 6'h08
`define TME_W_EVENT_ID 6'h02
`define TME_W_ACCESS_SIZE 6'h02
`define TME_W_OP_TYPE 6'h02
`define TME_W_BIT_INDEX 6'h05
`define TME_W_RESOURCE 6'h04
`define TME_W_CORR_EVENT 6'h04
`define TME_W_ERROR 6'h05
`define TME_W_WATCH_MASK 6'h08
`define TME_W_TRACE_WATCH 6'h02

// ----------------------------------------
// Packet slots and sequencer states
// ----------------------------------------
`define TME_MAX_PKTS 3'h4
`define TME_ST_IDLE 1'h0
`define TME_ST_SEND 1'h1

`endif

//--- tme_pkt_beats.v
`timescale 1ns/1ps

module tme_pkt_beats #(
  parameter PORT_W = 8
) (
  input wire [31:0] i_value,
  input wire [5:0] i_width,
  input wire i_var,
  output reg [5:0] o_beats
);

  integer bits;
  integer k;
  integer beats;

  // Variable packets keep only up to the highest one bit, never less than one bit
  always @* begin
    bits = i_width;
    if (i_var) begin
      bits = 1;
      for (k = 0; k < 32; k = k + 1) begin
        if (i_value[k] && (k < i_width)) begin
          bits = k + 1; // RL4
        end
      end
    end
    // Rounding up makes every packet end on a port boundary
    beats = (bits + PORT_W - 1) / PORT_W; // RL5
    o_beats = beats[5:0];
  end

endmodule

//--- tme_encoder.v
`timescale 1ns/1ps
`include "tme_defs.vh"

// Function
// [RL1] Type code first, then packets in order
// [RL2] Messages leave only on the trace port
// [RL3] Fixed packets full width, variable may shrink
// [RL4] Drop leading zeros; receiver assumes zeros
// [RL5] Shortened packets still end on boundary
// [RL6] Direct jump: code 3, count
// [RL7] Jump with target: 57, count, address
// [RL8] Indirect jump: 4, id, count, address
// [RL9] Program resync: 9, count, full PC
// [RL10] Direct jump resync: 11, count, full address
// [RL11] Indirect resync: 12, id, count, full address
// [RL12] Resource full: 27, kind, data byte
// [RL13] Correlation: 33, event code, count
// [RL14] Data write: 5, size, address, value
// [RL15] Data read: 6, size, address, value
// [RL16] Write resync: 13, size, full address, data
// [RL17] Read resync: 14, size, full address, data
// [RL18] Atomic update: 58, type, bit, address
// [RL19] Atomic resync: 59, type, bit, full address
// [RL20] Trace watch hit: 56, two-bit field
// [RL21] Code 63 never sent for events
// [RL22] Tool configures over JTAG, not here
// [RL23] Status, owner, error, watch hit encodings
// [RL24] Reserved type codes never transmitted
module tme_encoder #(
  parameter PORT_W = 8
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_msg_valid,
  input wire [4:0] i_msg_kind,
  input wire [7:0] i_code_field,
  input wire [4:0] i_bit_index,
  input wire [7:0] i_icount,
  input wire [31:0] i_addr,
  input wire [31:0] i_data,
  output wire o_msg_ready,
  output reg o_kind_error,
  output reg o_port_valid,
  output reg [PORT_W-1:0] o_port_data,
  output reg o_msg_start,
  output reg o_pkt_end,
  output reg o_msg_end
);

  // ----------------------------------------
  // Message assembly
  // ----------------------------------------
  reg state;
  reg [31:0] pk_val [0:3];
  reg [5:0] pk_w [0:3];
  reg [3:0] pk_var;
  reg [2:0] pk_num;
  reg [31:0] next_val1;
  reg [31:0] next_val2;
  reg [31:0] next_val3;
  reg [5:0] next_w1;
  reg [5:0] next_w2;
  reg [5:0] next_w3;
  reg [3:0] next_var;
  reg [2:0] next_num;
  reg [5:0] next_type;
  reg next_ok;
  wire accept;
  wire [5:0] beats [0:3];
  reg [1:0] cur;
  reg [5:0] beat;
  reg [31:0] shifter;
  wire [1:0] cur_next;
  wire last_beat;
  wire last_pkt;

  assign o_msg_ready = (state == `TME_ST_IDLE);
  assign accept = i_msg_valid && o_msg_ready && next_ok;

  // Unused slots stay zero width; small codes are masked to their field
  always @* begin
    next_ok = 1'b1;
    next_type = `TME_TC_DEBUG_STATE;
    next_num = 3'h2;
    next_val1 = 32'h0000_0000;
    next_val2 = 32'h0000_0000;
    next_val3 = 32'h0000_0000;
    next_w1 = 6'h00;
    next_w2 = 6'h00;
    next_w3 = 6'h00;
    next_var = 4'h0;
    case (i_msg_kind)
      `TME_KIND_DEBUG_STATE: begin
        next_type = `TME_TC_DEBUG_STATE; // RL23
        next_val1 = i_data;
        next_w1 = `TME_W_WORD;
        next_var = 4'h2;
      end
      `TME_KIND_OWNER_TRACE: begin
        next_type = `TME_TC_OWNER_TRACE; // RL23
        next_val1 = i_data;
        next_w1 = `TME_W_WORD;
        next_var = 4'h2;
      end
      `TME_KIND_ERROR: begin
        next_type = `TME_TC_ERROR; // RL23
        next_val1 = {27'h000_0000, i_code_field[4:0]};
        next_w1 = `TME_W_ERROR;
      end
      `TME_KIND_DIRECT_JUMP: begin
        next_type = `TME_TC_DIRECT_JUMP; // RL6
        next_val1 = {24'h00_0000, i_icount};
        next_w1 = `TME_W_COUNT;
        next_var = 4'h2;
      end
      `TME_KIND_DIRECT_JUMP_TARGET: begin
        next_type = `TME_TC_DIRECT_JUMP_TARGET; // RL7
        next_num = 3'h3;
        next_val1 = {24'h00_0000, i_icount};
        next_w1 = `TME_W_COUNT;
        next_val2 = i_addr;
        next_w2 = `TME_W_WORD;
        next_var = 4'h6;
      end
      `TME_KIND_INDIRECT_JUMP: begin
        next_type = `TME_TC_INDIRECT_JUMP; // RL8
        next_num = 3'h4;
        next_val1 = {30'h0000_0000, i_code_field[1:0]};
        next_w1 = `TME_W_EVENT_ID;
        next_val2 = {24'h00_0000, i_icount};
        next_w2 = `TME_W_COUNT;
        next_val3 = i_addr;
        next_w3 = `TME_W_WORD;
        next_var = 4'hc;
      end
      `TME_KIND_PROGRAM_RESYNC: begin
        next_type = `TME_TC_PROGRAM_RESYNC; // RL9
        next_num = 3'h3;
        next_val1 = {24'h00_0000, i_icount};
        next_w1 = `TME_W_COUNT;
        next_val2 = i_addr;
        next_w2 = `TME_W_WORD;
        next_var = 4'h2;
      end
      `TME_KIND_DIRECT_JUMP_RESYNC: begin
        next_type = `TME_TC_DIRECT_JUMP_RESYNC; // RL10
        next_num = 3'h3;
        next_val1 = {24'h00_0000, i_icount};
        next_w1 = `TME_W_COUNT;
        next_val2 = i_addr;
        next_w2 = `TME_W_WORD;
        next_var = 4'h2;
      end
      `TME_KIND_INDIRECT_JUMP_RESYNC: begin
        next_type = `TME_TC_INDIRECT_JUMP_RESYNC; // RL11
        next_num = 3'h4;
        next_val1 = {30'h0000_0000, i_code_field[1:0]};
        next_w1 = `TME_W_EVENT_ID;
        next_val2 = {24'h00_0000, i_icount};
        next_w2 = `TME_W_COUNT;
        next_val3 = i_addr;
        next_w3 = `TME_W_WORD;
        next_var = 4'h4;
      end
      `TME_KIND_RESOURCE_OVERFLOW: begin
        next_type = `TME_TC_RESOURCE_OVERFLOW; // RL12
        next_num = 3'h3;
        next_val1 = {28'h000_0000, i_code_field[3:0]};
        next_w1 = `TME_W_RESOURCE;
        next_val2 = {24'h00_0000, i_data[7:0]};
        next_w2 = `TME_W_COUNT;
        next_var = 4'h4;
      end
      `TME_KIND_CORRELATION: begin
        next_type = `TME_TC_CORRELATION; // RL13
        next_num = 3'h3;
        next_val1 = {28'h000_0000, i_code_field[3:0]};
        next_w1 = `TME_W_CORR_EVENT;
        next_val2 = {24'h00_0000, i_icount};
        next_w2 = `TME_W_COUNT;
        next_var = 4'h4;
      end
      `TME_KIND_WRITE_TRACE, `TME_KIND_READ_TRACE: begin
        if (i_msg_kind == `TME_KIND_WRITE_TRACE) begin
          next_type = `TME_TC_WRITE_TRACE; // RL14
        end else begin
          next_type = `TME_TC_READ_TRACE; // RL15
        end
        next_num = 3'h4;
        next_val1 = {30'h0000_0000, i_code_field[1:0]};
        next_w1 = `TME_W_ACCESS_SIZE;
        next_val2 = i_addr;
        next_w2 = `TME_W_WORD;
        next_val3 = i_data;
        next_w3 = `TME_W_WORD;
        next_var = 4'hc;
      end
      `TME_KIND_WRITE_TRACE_RESYNC, `TME_KIND_READ_TRACE_RESYNC: begin
        if (i_msg_kind == `TME_KIND_WRITE_TRACE_RESYNC) begin
          next_type = `TME_TC_WRITE_TRACE_RESYNC; // RL16
        end else begin
          next_type = `TME_TC_READ_TRACE_RESYNC; // RL17
        end
        next_num = 3'h4;
        next_val1 = {30'h0000_0000, i_code_field[1:0]};
        next_w1 = `TME_W_ACCESS_SIZE;
        next_val2 = i_addr;
        next_w2 = `TME_W_WORD;
        next_val3 = i_data;
        next_w3 = `TME_W_WORD;
        next_var = 4'h8;
      end
      `TME_KIND_ATOMIC_UPDATE, `TME_KIND_ATOMIC_UPDATE_RESYNC: begin
        if (i_msg_kind == `TME_KIND_ATOMIC_UPDATE) begin
          next_type = `TME_TC_ATOMIC_UPDATE; // RL18
          next_var = 4'h8;
        end else begin
          next_type = `TME_TC_ATOMIC_UPDATE_RESYNC; // RL19
          next_var = 4'h0;
        end
        next_num = 3'h4;
        next_val1 = {30'h0000_0000, i_code_field[1:0]};
        next_w1 = `TME_W_OP_TYPE;
        next_val2 = {27'h000_0000, i_bit_index};
        next_w2 = `TME_W_BIT_INDEX;
        next_val3 = i_addr;
        next_w3 = `TME_W_WORD;
      end
      `TME_KIND_WATCH_HIT: begin
        next_type = `TME_TC_WATCH_HIT; // RL23
        next_val1 = {24'h00_0000, i_code_field};
        next_w1 = `TME_W_WATCH_MASK;
        next_var = 4'h2;
      end
      `TME_KIND_TRACE_WATCH_HIT: begin
        next_type = `TME_TC_TRACE_WATCH_HIT; // RL20
        next_val1 = {30'h0000_0000, i_code_field[1:0]};
        next_w1 = `TME_W_TRACE_WATCH;
      end
      default: begin
        // Unknown kinds are dropped, so no reserved or extension code leaves
        next_ok = 1'b0; // RL21 RL24
      end
    endcase
  end

  // ----------------------------------------
  // Packet length per slot
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_len
      tme_pkt_beats #(
        .PORT_W(PORT_W)
      ) u_len (
        .i_value(pk_val[g]),
        .i_width(pk_w[g]),
        .i_var(pk_var[g]), // RL3
        .o_beats(beats[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Serialiser onto the trace port
  // ----------------------------------------
  assign cur_next = cur + 2'h1;
  assign last_beat = (beat == beats[cur] - 6'h01);
  assign last_pkt = ({1'b0, cur} == pk_num - 3'h1);

  // Slot 0 always holds the type code, a fixed packet
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= `TME_ST_IDLE;
      pk_val[0] <= 32'h0000_0000;
      pk_val[1] <= 32'h0000_0000;
      pk_val[2] <= 32'h0000_0000;
      pk_val[3] <= 32'h0000_0000;
      pk_w[0] <= 6'h00;
      pk_w[1] <= 6'h00;
      pk_w[2] <= 6'h00;
      pk_w[3] <= 6'h00;
      pk_var <= 4'h0;
      pk_num <= 3'h0;
      cur <= 2'h0;
      beat <= 6'h00;
      shifter <= 32'h0000_0000;
      o_kind_error <= 1'b0;
      o_port_valid <= 1'b0;
      o_port_data <= {PORT_W{1'b0}};
      o_msg_start <= 1'b0;
      o_pkt_end <= 1'b0;
      o_msg_end <= 1'b0;
    end else begin
      o_kind_error <= i_msg_valid && o_msg_ready && !next_ok;
      o_port_valid <= 1'b0;
      o_msg_start <= 1'b0;
      o_pkt_end <= 1'b0;
      o_msg_end <= 1'b0;
      case (state)
        `TME_ST_IDLE: begin
          if (accept) begin
            pk_val[0] <= {26'h000_0000, next_type}; // RL1
            pk_w[0] <= `TME_W_TYPE;
            pk_val[1] <= next_val1;
            pk_val[2] <= next_val2;
            pk_val[3] <= next_val3;
            pk_w[1] <= next_w1;
            pk_w[2] <= next_w2;
            pk_w[3] <= next_w3;
            pk_var <= next_var;
            pk_num <= next_num;
            cur <= 2'h0;
            beat <= 6'h00;
            shifter <= {26'h000_0000, next_type};
            state <= `TME_ST_SEND;
          end
        end
        `TME_ST_SEND: begin
          // One beat per clock; the far end must take every beat
          o_port_valid <= 1'b1; // RL2
          o_port_data <= shifter[PORT_W-1:0];
          o_msg_start <= (cur == 2'h0) && (beat == 6'h00);
          o_pkt_end <= last_beat; // RL5
          o_msg_end <= last_beat && last_pkt;
          shifter <= shifter >> PORT_W;
          beat <= beat + 6'h01;
          if (last_beat) begin
            beat <= 6'h00;
            if (last_pkt) begin
              state <= `TME_ST_IDLE;
            end else begin
              cur <= cur_next; // RL1
              shifter <= pk_val[cur_next];
            end
          end
        end
        default: begin
          state <= `TME_ST_IDLE;
        end
      endcase
    end
  end

endmodule

//--- tme_enc_properties.sv
`timescale 1ns/1ps
module tme_enc_props #(
  parameter PORT_W = 8
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_msg_valid,
  input wire [4:0] i_msg_kind,
  input wire o_msg_ready,
  input wire o_kind_error,
  input wire o_port_valid,
  input wire [PORT_W-1:0] o_port_data,
  input wire o_msg_start,
  input wire o_pkt_end,
  input wire o_msg_end
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_take;
    i_msg_valid && o_msg_ready && i_msg_kind < 5'h13 |=> !o_msg_ready ##1 o_msg_start;
  endproperty
  a_take: assert property (p_take) else $error("message start late");
  property p_refuse;
    i_msg_valid && o_msg_ready && i_msg_kind > 5'h12 |=> o_kind_error && o_msg_ready && !o_port_valid;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad kind not refused");
  property p_err_cause;
    o_kind_error |-> $past(i_msg_valid) && $past(o_msg_ready) && $past(i_msg_kind) > 5'h12;
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("spurious kind error");
  property p_message_type_code;
    o_msg_start |-> o_port_valid && o_port_data[7:6] == 2'h0
      && !(o_port_data[5:0] inside {1, 7, 10, [16:26], [28:32], [34:55], [60:63]});
  endproperty
  a_message_type_code: assert property (p_message_type_code) else $error("illegal type code");
  property p_end;
    o_msg_end |-> o_pkt_end && o_port_valid;
  endproperty
  a_end: assert property (p_end) else $error("message end off packet end");
  property p_gap;
    o_msg_end |-> o_msg_ready ##1 !o_port_valid;
  endproperty
  a_gap: assert property (p_gap) else $error("no idle after message");
  property p_contig;
    o_port_valid && !o_msg_end |=> o_port_valid && !o_msg_start;
  endproperty
  a_contig: assert property (p_contig) else $error("message broken");
  property p_first;
    $rose(o_port_valid) |-> o_msg_start;
  endproperty
  a_first: assert property (p_first) else $error("message without type code");
  property p_direct;
    o_msg_start && o_port_data[5:0] == 6'h03 |-> o_pkt_end ##1 o_pkt_end && o_msg_end;
  endproperty
  a_direct: assert property (p_direct) else $error("direct jump length");
  property p_sync;
    o_msg_start && o_port_data[5:0] == 6'h09 |=> o_pkt_end ##1 !o_pkt_end [*3] ##1 o_msg_end;
  endproperty
  a_sync: assert property (p_sync) else $error("full address shortened");
  property p_twatch;
    o_msg_start && o_port_data[5:0] == 6'h38 |=> o_msg_end && o_port_data[7:2] == 6'h00;
  endproperty
  a_twatch: assert property (p_twatch) else $error("watch field length");
endmodule

bind tme_encoder tme_enc_props #(.PORT_W(PORT_W)) i_props (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_msg_valid(i_msg_valid), .i_msg_kind(i_msg_kind),
  .o_msg_ready(o_msg_ready), .o_kind_error(o_kind_error), .o_port_valid(o_port_valid),
  .o_port_data(o_port_data), .o_msg_start(o_msg_start), .o_pkt_end(o_pkt_end),
  .o_msg_end(o_msg_end)
);

//--- tme_rx_model.sv
`timescale 1ns/1ps
module tme_rx_model #(
  parameter PORT_W = 8
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_valid,
  input wire [PORT_W-1:0] i_data,
  input wire i_start,
  input wire i_pkt_end,
  input wire i_msg_end
);
  // Listen only: no path back up the trace port
  logic [PORT_W+2:0] q[$];
  logic [31:0] pkt_val = 32'h0000_0000;
  int pkt_beat = 0;
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      pkt_beat = 0;
    end else if (i_valid) begin
      q.push_back({i_start, i_pkt_end, i_msg_end, i_data});
      // Fresh packet starts from zero, so dropped upper bits read as zero
      if (pkt_beat == 0)
        pkt_val = 32'(i_data);
      else
        pkt_val = pkt_val | (32'(i_data) << (PORT_W * pkt_beat));
      pkt_beat = i_pkt_end ? 0 : pkt_beat + 1;
    end
  end
endmodule

//--- trace_message_encoder_tb.sv
`timescale 1ns/1ps
module trace_message_encoder_tb;
  reg i_clk = 1'b0;
  reg i_nrst = 1'b0;
  reg i_msg_valid = 1'b0;
  reg [4:0] i_msg_kind = 5'h00;
  reg [7:0] i_code_field = 8'h00;
  reg [4:0] i_bit_index = 5'h00;
  reg [7:0] i_icount = 8'h00;
  reg [31:0] i_addr = 32'h0000_0000;
  reg [31:0] i_data = 32'h0000_0000;
  wire o_msg_ready, o_kind_error, o_port_valid, o_msg_start, o_pkt_end, o_msg_end;
  wire [7:0] o_port_data;
  int failures = 0;
  int checked = 0;
  int base = 0;
  logic [10:0] eq[$];

  always #10 i_clk = ~i_clk;

  tme_encoder #(.PORT_W(8)) i_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_msg_valid(i_msg_valid), .i_msg_kind(i_msg_kind),
    .i_code_field(i_code_field), .i_bit_index(i_bit_index), .i_icount(i_icount),
    .i_addr(i_addr), .i_data(i_data), .o_msg_ready(o_msg_ready),
    .o_kind_error(o_kind_error), .o_port_valid(o_port_valid), .o_port_data(o_port_data),
    .o_msg_start(o_msg_start), .o_pkt_end(o_pkt_end), .o_msg_end(o_msg_end));

  tme_rx_model #(.PORT_W(8)) i_rx (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_valid(o_port_valid), .i_data(o_port_data),
    .i_start(o_msg_start), .i_pkt_end(o_pkt_end), .i_msg_end(o_msg_end));

  // ----
  // Expected framing
  // ----
  // Type code in bits 19:12, then three packet selectors
  function automatic [19:0] fmt(input [4:0] k);
    case (k)
      5'h00: fmt = 20'h0_0800;
      5'h01: fmt = 20'h0_2800;
      5'h02: fmt = 20'h0_8300;
      5'h03: fmt = 20'h0_3500;
      5'h04: fmt = 20'h3_9560;
      5'h05: fmt = 20'h0_4156;
      5'h06: fmt = 20'h0_9570;
      5'h07: fmt = 20'h0_b570;
      5'h08: fmt = 20'h0_c157;
      5'h09: fmt = 20'h1_b2a0;
      5'h0a: fmt = 20'h2_1250;
      5'h0b: fmt = 20'h0_5168;
      5'h0c: fmt = 20'h0_6168;
      5'h0d: fmt = 20'h3_a196;
      5'h0e: fmt = 20'h0_d178;
      5'h0f: fmt = 20'h0_e178;
      5'h10: fmt = 20'h3_b197;
      5'h11: fmt = 20'h0_f400;
      5'h12: fmt = 20'h3_8100;
      default: fmt = 20'h0_0000;
    endcase
  endfunction

  task automatic pk(input [31:0] v, input int w, input bit vr);
    int b;
    int n;
    b = w;
    if (vr) begin
      b = 1;
      for (int i = 0; i < w; i++) if (v[i]) b = i + 1;
    end
    n = (b + 7) / 8;
    for (int j = 0; j < n; j++)
      eq.push_back({eq.size() == 0, j == n - 1, 1'b0, 8'(v >> (8 * j))});
  endtask

  task automatic pkt(input [3:0] s);
    case (s)
      4'h1: pk(i_code_field[1:0], 2, 0);
      4'h2: pk(i_code_field[3:0], 4, 0);
      4'h3: pk(i_code_field[4:0], 5, 0);
      4'h4: pk(i_code_field, 8, 1);
      4'h5: pk(i_icount, 8, 1);
      4'h6: pk(i_addr, 32, 1);
      4'h7: pk(i_addr, 32, 0);
      4'h8: pk(i_data, 32, 1);
      4'h9: pk(i_bit_index, 5, 0);
      4'ha: pk(i_data[7:0], 8, 1);
      default: ;
    endcase
  endtask

  task automatic build(input [4:0] k);
    logic [19:0] f;
    f = fmt(k);
    eq.delete();
    pk(f[19:12], 6, 0);
    pkt(f[11:8]);
    pkt(f[7:4]);
    pkt(f[3:0]);
    eq[eq.size() - 1][8] = 1'b1;
  endtask

  // ----
  // Drivers and compares
  // ----
  task automatic send(input [4:0] k);
    int n;
    n = 0;
    i_msg_kind = k;
    i_msg_valid = 1'b1;
    while (o_msg_ready !== 1'b1 && n < 100) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk_bit("ready", 1'b1, o_msg_ready);
    @(posedge i_clk);
    #1;
    i_msg_valid = 1'b0;
  endtask

  task automatic chk_vec(input string nm, input [10:0] e, input [10:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk_bit(input string nm, input e, input s);
    chk_vec(nm, {10'h000, e}, {10'h000, s});
  endtask

  task automatic chk_word(input string nm, input [31:0] e, input [31:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Beats are held by the model, so a short message times out as unknowns
  task automatic chk_stream();
    int n;
    n = 0;
    while (i_rx.q.size() < base + eq.size() && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    #1;
    foreach (eq[i]) chk_vec("beat", eq[i], i_rx.q[base + i]);
    base = base + eq.size();
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_all_kinds(input [7:0] c, input [4:0] b, input [7:0] n,
                             input [31:0] a, input [31:0] d);
    i_code_field = c;
    i_bit_index = b;
    i_icount = n;
    i_addr = a;
    i_data = d;
    for (int k = 0; k < 19; k++) begin
      build(k[4:0]);
      send(k[4:0]);
      chk_stream();
      // Shortened target address rebuilt with zero upper bits
      if (k == 4)
        chk_word("target", i_addr, i_rx.pkt_val);
    end
  endtask

  task automatic t_bad_kind();
    int b;
    b = i_rx.q.size();
    i_msg_valid = 1'b1;
    for (int k = 19; k < 32; k++) begin
      i_msg_kind = k[4:0];
      @(posedge i_clk);
      #1;
      chk_bit("kind_error", 1'b1, o_kind_error);
      chk_bit("ready", 1'b1, o_msg_ready);
    end
    i_msg_valid = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    chk_vec("beats", 11'(b), 11'(i_rx.q.size()));
  endtask

  task automatic t_reset_mid();
    i_addr = 32'hffff_ffff;
    i_data = 32'hffff_ffff;
    send(5'h0b);
    repeat (3) @(posedge i_clk);
    #1;
    i_nrst = 1'b0;
    #1;
    chk_bit("port_valid", 1'b0, o_port_valid);
    chk_bit("ready", 1'b1, o_msg_ready);
    @(posedge i_clk);
    #1;
    i_nrst = 1'b1;
    base = i_rx.q.size();
    build(5'h03);
    send(5'h03);
    chk_stream();
  endtask

  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    #1;
    i_nrst = 1'b1;
    t_all_kinds(8'h00, 5'h00, 8'h00, 32'h0000_0000, 32'h0000_0000);
    t_all_kinds(8'hff, 5'h1f, 8'hff, 32'hffff_ffff, 32'hffff_ffff);
    t_all_kinds(8'h5a, 5'h09, 8'h01, 32'h0001_2345, 32'h0000_0180);
    t_bad_kind();
    t_reset_mid();
    end_sim();
  end

  // A hang costs far more than the roughly 430 cycles of real traffic
  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule
